/* src/scdp_params.svh */
// Operation
// - data registers answer the host at any moment, whatever the serial machines do
// - writing transmit byte pushes byte plus transmit flags as one transmit FIFO entry; the write is dropped while the FIFO is full
// - transmit byte register is write only; reads return zero
// - in multidrop mode the pushed address marker is sent as marker bit
// - in software parity mode the pushed parity bit replaces computed parity
// - in nine-bit mode the pushed ninth bit is sent as data MSB
// - receive character register always shows the oldest received character
// - received character right justified, bits above character length read zero
// - first character into an empty receive path is readable at once
// - reading receive character advances FIFO to next character and its flags
// - internal clock is input clock, or input halved when halving selected
// - receive flags hold the ninth bit, zero for characters under nine bits
// - each FIFO occupancy reported as three-bit count from zero to four
// - while receive FIFO is locked, new characters are discarded
`ifndef SCDP_PARAMS_SVH
`define SCDP_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCDP_AW           3
`define SCDP_OFS_TXB      3'h0
`define SCDP_OFS_TXF      3'h1
`define SCDP_OFS_RXC      3'h2
`define SCDP_OFS_RXF      3'h3
`define SCDP_OFS_FLR      3'h4
`define SCDP_OFS_CFG      3'h5
`define SCDP_OFS_CMD      3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCDP_TXF_NINTH    0
`define SCDP_TXF_PARITY   1
`define SCDP_TXF_MARKER   2
`define SCDP_CFG_LEN_LO   0
`define SCDP_CFG_LEN_HI   2
`define SCDP_CFG_SWPAR    3
`define SCDP_CFG_MDROP    4
`define SCDP_CFG_HALVE    5
`define SCDP_CMD_LOCK     0
`define SCDP_CMD_UNLOCK   1
`define SCDP_CMD_FLUSH_RX 2
`define SCDP_CMD_FLUSH_TX 3

// ----------------------------------------
// reset values and depths
// ----------------------------------------
`define SCDP_TXF_RST      8'h00
`define SCDP_CFG_RST      8'h03
`define SCDP_DEPTH        3'h4
`define SCDP_LEN9_CODE    3'h4

`endif

/* src/scdp_pkg.sv */
package scdp_pkg;

  // transmit FIFO entry
  typedef struct packed {
    logic       marker;
    logic       parity;
    logic [8:0] data;
  } scdp_tx_ent_t;

  // receive FIFO entry: status flags above the character
  typedef struct packed {
    logic [6:0] stat;
    logic [8:0] data;
  } scdp_rx_ent_t;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } scdp_bus_t;

  // whole module state
  typedef struct packed {
    scdp_tx_ent_t [3:0] tx_mem;
    logic [1:0]         tx_wp;
    logic [1:0]         tx_rp;
    logic [2:0]         tx_cnt;
    scdp_rx_ent_t [3:0] rx_mem;
    logic [1:0]         rx_wp;
    logic [1:0]         rx_rp;
    logic [2:0]         rx_cnt;
    logic [7:0]         transmit_extra_bits;
    logic [7:0]         cfg;
    logic               lock;
    logic               div;
    logic               sys_en;
    logic [7:0]         rdata;
    logic               tx_valid;
    scdp_tx_ent_t       tx_head;
    logic               rx_drop;
  } scdp_state_t;

endpackage

/* src/scdp_data_path.sv */
`timescale 1ns/100ps
`include "scdp_params.svh"

module scdp_data_path
  import scdp_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  input  wire logic [2:0]         i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output      logic [7:0]         o_rdata,
  input  wire logic               i_tx_take,
  output      logic               o_tx_valid,
  output      scdp_tx_ent_t       o_tx_entry,
  input  wire logic               i_rx_valid,
  input  wire logic [8:0]         i_rx_char,
  input  wire logic [6:0]         i_rx_stat,
  output      logic               o_rx_drop,
  output      logic               o_sys_clk_en
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // mask of valid data bits for a length code (0 = 5 bits .. 4 = 9 bits)
  function automatic logic [8:0] len_mask(input logic [2:0] code);
    logic [8:0] m;
    m = 9'h1ff;
    if (code < `SCDP_LEN9_CODE) begin
      m = 9'h1ff >> (3'h4 - code);
    end
    return m;
  endfunction

  // character length code held in the configuration byte
  function automatic logic [2:0] len_code_of(input logic [7:0] cfg);
    logic [2:0] code;
    code = cfg[`SCDP_CFG_LEN_HI:`SCDP_CFG_LEN_LO];
    return code;
  endfunction

  // strobe aimed at one register offset
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [2:0] addr,
                                   input logic [2:0] ofs);
    logic hit;
    hit = strobe && (addr == ofs);
    return hit;
  endfunction

  // ring holds no entry
  function automatic logic fifo_empty(input logic [2:0] cnt);
    logic empty;
    empty = (cnt == 3'h0);
    return empty;
  endfunction

  // ring holds all four entries
  function automatic logic fifo_full(input logic [2:0] cnt);
    logic full;
    full = (cnt == `SCDP_DEPTH);
    return full;
  endfunction

  // ring pointer step, wraps over four slots
  function automatic logic [1:0] ptr_step(input logic [1:0] ptr,
                                          input logic       adv);
    logic [1:0] p;
    p = ptr;
    if (adv) begin
      p = ptr + 2'h1;
    end
    return p;
  endfunction

  // occupancy after one optional push and one optional pop
  function automatic logic [2:0] cnt_step(input logic [2:0] cnt,
                                          input logic       inc,
                                          input logic       dec);
    logic [2:0] c;
    c = cnt;
    if (inc && !dec) begin
      c = cnt + 3'h1;
    end
    if (dec && !inc) begin
      c = cnt - 3'h1;
    end
    return c;
  endfunction

  // transmit entry from byte, flags and the modes in force at push time
  function automatic scdp_tx_ent_t tx_pack(input logic [7:0] byte_in,
                                           input logic [7:0] flags,
                                           input logic [7:0] cfg);
    scdp_tx_ent_t e;
    logic [2:0]   code;
    code     = len_code_of(cfg);
    e.data   = {flags[`SCDP_TXF_NINTH] && (code >= `SCDP_LEN9_CODE), byte_in} & len_mask(code);
    e.parity = flags[`SCDP_TXF_PARITY] && cfg[`SCDP_CFG_SWPAR];
    e.marker = flags[`SCDP_TXF_MARKER] && cfg[`SCDP_CFG_MDROP];
    return e;
  endfunction

  // presented receive character, zero while nothing is held
  function automatic logic [7:0] rx_head_char(input scdp_state_t st);
    logic [7:0] c;
    c = 8'h00;
    if (!fifo_empty(st.rx_cnt)) begin
      c = st.rx_mem[st.rx_rp].data[7:0];
    end
    return c;
  endfunction

  // presented receive flags, status above the ninth bit
  function automatic logic [7:0] rx_head_flags(input scdp_state_t st);
    logic [7:0] f;
    f = 8'h00;
    if (!fifo_empty(st.rx_cnt)) begin
      f = {st.rx_mem[st.rx_rp].stat, st.rx_mem[st.rx_rp].data[8]};
    end
    return f;
  endfunction

  // occupancy byte, transmit count high, receive count low
  function automatic logic [7:0] flr_pack(input logic [2:0] tx_cnt,
                                          input logic [2:0] rx_cnt);
    logic [7:0] f;
    f = {1'b0, tx_cnt, 1'b0, rx_cnt};
    return f;
  endfunction

  // read data for one offset, zero for write-only and unmapped offsets
  function automatic logic [7:0] read_mux(input scdp_state_t st,
                                          input logic [2:0]  addr);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      `SCDP_OFS_TXB: begin
        d = 8'h00;
      end
      `SCDP_OFS_TXF: begin
        d = st.transmit_extra_bits;
      end
      `SCDP_OFS_RXC: begin
        d = rx_head_char(st);
      end
      `SCDP_OFS_RXF: begin
        d = rx_head_flags(st);
      end
      `SCDP_OFS_FLR: begin
        d = flr_pack(st.tx_cnt, st.rx_cnt);
      end
      `SCDP_OFS_CFG: begin
        d = st.cfg;
      end
      default: begin
        d = 8'h00;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  scdp_state_t s_r;
  scdp_state_t s_nxt;
  scdp_bus_t   bus;

  logic [2:0]  len_code;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_in;
  logic        rx_push;
  logic        rx_pop;
  logic        rxc_sel;
  logic        cmd_sel;
  logic [8:0]  rx_clean;
  logic        lock_set;
  logic        lock_clr;
  logic        flush_rx;
  logic        flush_tx;

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // decode of strobes and handshakes
  always_comb begin
    len_code = len_code_of(s_r.cfg);
    rxc_sel  = reg_hit(bus.rd, bus.addr, `SCDP_OFS_RXC);
    cmd_sel  = reg_hit(bus.wr, bus.addr, `SCDP_OFS_CMD);
    lock_set = cmd_sel && bus.wdata[`SCDP_CMD_LOCK];
    lock_clr = cmd_sel && bus.wdata[`SCDP_CMD_UNLOCK];
    flush_rx = cmd_sel && bus.wdata[`SCDP_CMD_FLUSH_RX];
    flush_tx = cmd_sel && bus.wdata[`SCDP_CMD_FLUSH_TX];
    tx_push  = reg_hit(bus.wr, bus.addr, `SCDP_OFS_TXB) && !fifo_full(s_r.tx_cnt);
    tx_pop   = s_r.sys_en && i_tx_take && !fifo_empty(s_r.tx_cnt);
    rx_in    = s_r.sys_en && i_rx_valid;
    rx_push  = rx_in && !s_r.lock && !fifo_full(s_r.rx_cnt);
    rx_pop   = rxc_sel && !fifo_empty(s_r.rx_cnt);
    rx_clean = i_rx_char & len_mask(len_code);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;

    // clock source: every cycle, or every second cycle when halved
    if (s_r.cfg[`SCDP_CFG_HALVE]) begin
      s_nxt.div    = ~s_r.div;
      s_nxt.sys_en = ~s_r.div;
    end else begin
      s_nxt.div    = 1'b0;
      s_nxt.sys_en = 1'b1;
    end

    // register writes, never stalled by the serial side
    if (bus.wr) begin
      case (bus.addr)
        `SCDP_OFS_TXF: begin
          s_nxt.transmit_extra_bits = bus.wdata;
        end
        `SCDP_OFS_CFG: begin
          s_nxt.cfg = bus.wdata;
        end
        default: begin
          s_nxt.cfg = s_r.cfg;
        end
      endcase
    end

    // lock and unlock of the receive write path
    if (lock_set) begin
      s_nxt.lock = 1'b1;
    end
    if (lock_clr) begin
      s_nxt.lock = 1'b0;
    end

    // register reads, answered in the next cycle
    if (bus.rd) begin
      s_nxt.rdata = read_mux(s_r, bus.addr);
    end

    // transmit FIFO: byte with mode-qualified flags
    if (tx_push) begin
      s_nxt.tx_mem[s_r.tx_wp] = tx_pack(bus.wdata, s_r.transmit_extra_bits, s_r.cfg);
    end
    // pointers and count of the transmit ring
    s_nxt.tx_wp  = ptr_step(s_r.tx_wp, tx_push);
    s_nxt.tx_rp  = ptr_step(s_r.tx_rp, tx_pop);
    s_nxt.tx_cnt = cnt_step(s_r.tx_cnt, tx_push, tx_pop);

    // receive FIFO: head is the presented character
    if (rx_push) begin
      s_nxt.rx_mem[s_r.rx_wp].data = rx_clean;
      s_nxt.rx_mem[s_r.rx_wp].stat = i_rx_stat;
    end
    // pointers and count of the receive ring
    s_nxt.rx_wp   = ptr_step(s_r.rx_wp, rx_push);
    s_nxt.rx_rp   = ptr_step(s_r.rx_rp, rx_pop);
    s_nxt.rx_cnt  = cnt_step(s_r.rx_cnt, rx_push, rx_pop);
    s_nxt.rx_drop = rx_in && !rx_push;

    // flush commands override the pointers
    if (flush_tx) begin
      s_nxt.tx_wp  = 2'h0;
      s_nxt.tx_rp  = 2'h0;
      s_nxt.tx_cnt = 3'h0;
    end
    if (flush_rx) begin
      s_nxt.rx_wp  = 2'h0;
      s_nxt.rx_rp  = 2'h0;
      s_nxt.rx_cnt = 3'h0;
    end

    // transmit head as seen by the serial machine next cycle
    s_nxt.tx_valid = !fifo_empty(s_nxt.tx_cnt);
    s_nxt.tx_head  = s_nxt.tx_mem[s_nxt.tx_rp];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r        <= '0;
      s_r.transmit_extra_bits    <= `SCDP_TXF_RST;
      s_r.cfg    <= `SCDP_CFG_RST;
      s_r.sys_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign o_rdata      = s_r.rdata;
  assign o_tx_valid   = s_r.tx_valid;
  assign o_tx_entry   = s_r.tx_head;
  assign o_rx_drop    = s_r.rx_drop;
  assign o_sys_clk_en = s_r.sys_en;

endmodule

/* verification/scdp_checker.sv */
`timescale 1ns/100ps
module scdp_checker
  import scdp_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_sys_rst,
  input wire logic [2:0]   i_addr,
  input wire logic         i_wr,
  input wire logic         i_rd,
  input wire logic [7:0]   o_rdata,
  input wire logic         i_tx_take,
  input wire logic         o_tx_valid,
  input wire scdp_tx_ent_t o_tx_entry,
  input wire logic         i_rx_valid,
  input wire logic         o_rx_drop,
  input wire logic         o_sys_clk_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("stray rdata");
  wo_read_a: assert property (i_rd && (i_addr == 3'h0 || i_addr > 3'h5) |=> o_rdata == 8'h00)
    else $error("hidden rdata");
  tx_push_a: assert property (i_wr && i_addr == 3'h0 |=> o_tx_valid)
    else $error("push lost");
  tx_rise_a: assert property ($rose(o_tx_valid) |-> $past(i_wr) && $past(i_addr) == 3'h0)
    else $error("no push");
  tx_fall_a: assert property ($fell(o_tx_valid) |-> $past(i_tx_take) || $past(i_wr))
    else $error("entry lost");
  head_hold_a: assert property (o_tx_valid && !i_tx_take && !i_wr |=> o_tx_valid && $stable(o_tx_entry))
    else $error("head moved");
  rx_drop_a: assert property (o_rx_drop |-> $past(i_rx_valid) && $past(o_sys_clk_en))
    else $error("bad drop");
  clk_en_a: assert property (!o_sys_clk_en |=> o_sys_clk_en)
    else $error("enable stuck");
  take_c: cover property (i_tx_take && o_tx_valid && o_sys_clk_en);
  drop_c: cover property (o_rx_drop);
  half_c: cover property (!o_sys_clk_en);
endmodule
bind scdp_data_path scdp_checker scdp_checker_i (.i_clk, .i_sys_rst, .i_addr, .i_wr, .i_rd, .o_rdata,
  .i_tx_take, .o_tx_valid, .o_tx_entry, .i_rx_valid, .o_rx_drop, .o_sys_clk_en);

/* verification/scdp_serial_model.sv */
`timescale 1ns/100ps
module scdp_serial_model (
  input  wire logic       i_clk,
  input  wire logic       i_sys_en,
  output      logic       o_rx_valid = 1'b0,
  output      logic [8:0] o_rx_char  = 9'h000,
  output      logic [6:0] o_rx_stat  = 7'h00,
  output      logic       o_tx_take  = 1'b0
);
  // one character offered, held until an enabled edge
  task automatic offer(input logic [8:0] c, input logic [6:0] s);
    o_rx_char  <= c;
    o_rx_stat  <= s;
    o_rx_valid <= 1'b1;
    do @(posedge i_clk); while (!i_sys_en);
    o_rx_valid <= 1'b0;
    o_rx_char  <= ~c; // released lines lose the value
  endtask
  // head entry taken at an enabled edge
  task automatic take;
    o_tx_take <= 1'b1;
    do @(posedge i_clk); while (!i_sys_en);
    o_tx_take <= 1'b0;
  endtask
endmodule

/* verification/scdp_data_path_tb.sv */
`timescale 1ns/100ps
module scdp_data_path_tb
  import scdp_pkg::*;
;
  logic         i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [2:0]   i_addr = 3'h0;
  logic [7:0]   i_wdata = 8'h00, o_rdata;
  logic         i_tx_take, o_tx_valid, i_rx_valid, o_rx_drop, o_sys_clk_en;
  logic [8:0]   i_rx_char;
  logic [6:0]   i_rx_stat;
  scdp_tx_ent_t o_tx_entry;
  int           n_mismatch = 0, n_compared = 0;
  logic [2:0]   n_en = 3'h0;
  scdp_data_path scdp_data_path_i (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_take,
    .o_tx_valid, .o_tx_entry, .i_rx_valid, .i_rx_char, .i_rx_stat, .o_rx_drop, .o_sys_clk_en);
  scdp_serial_model scdp_serial_model_i (.i_clk, .i_sys_en(o_sys_clk_en), .o_rx_valid(i_rx_valid),
    .o_rx_char(i_rx_char), .o_rx_stat(i_rx_stat), .o_tx_take(i_tx_take));
  always #50 i_clk = ~i_clk;
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  // write strobe stays up until the next rd or cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
  endtask
  task automatic cyc;
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    i_wr   <= 1'b0;
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk({3'h0, o_rdata}, {3'h0, e});
    @(posedge i_clk);
  endtask
  task automatic end_sim;
    $display("compared %0d bad %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(3'h5, 8'h03);
    wr(3'h5, 8'h1c);
    wr(3'h1, 8'h07);
    wr(3'h0, 8'ha5);
    cyc;
    chk(o_tx_entry, 11'h7a5);
    chk({10'h000, o_tx_valid}, 11'h001);
    rd(3'h0, 8'h00);
    wr(3'h5, 8'h03);
    repeat (4) wr(3'h0, 8'h5a);
    rd(3'h4, 8'h40);
    scdp_serial_model_i.take;
    rd(3'h4, 8'h30);
    chk(o_tx_entry, 11'h05a);
    wr(3'h6, 8'h08);
    wr(3'h5, 8'h00);
    cyc;
    scdp_serial_model_i.offer(9'h1ff, 7'h00);
    wr(3'h5, 8'h04);
    cyc;
    scdp_serial_model_i.offer(9'h1c3, 7'h05);
    rd(3'h2, 8'h1f);
    rd(3'h3, 8'h0b);
    rd(3'h2, 8'hc3);
    rd(3'h2, 8'h00);
    wr(3'h5, 8'h20);
    cyc;
    repeat (4) begin
      @(negedge i_clk);
      n_en = n_en + {2'h0, o_sys_clk_en};
    end
    chk({8'h00, n_en}, 11'h002);
    @(posedge i_clk);
    scdp_serial_model_i.offer(9'h1ea, 7'h00);
    rd(3'h2, 8'h0a);
    wr(3'h6, 8'h01);
    cyc;
    scdp_serial_model_i.offer(9'h055, 7'h00);
    @(negedge i_clk);
    chk({10'h000, o_rx_drop}, 11'h001);
    @(posedge i_clk);
    rd(3'h4, 8'h00);
    end_sim;
  end
endmodule
